// *** bench/dac_device_model.sv ***
// Purpose: behavioural model of the dac digital input logic
// Assumes: pins driven by the host controller, no clock
// Notes: op_hist logs the op of every latching edge
`timescale 1ns/1ps
module dac_device_model
  import dac_port_pkg::*;
(
  input wire logic [1:0] op_addr, // op
  input wire logic [3:0] nibble, // data
  input wire logic sel_n, // select
  input wire logic wr_n, // strobe
  input wire logic zeroize_n, // clear
  output logic [11:0] nibbles_reg, // high, middle, low
  output logic [11:0] converter_code, // converter
  output logic [7:0] op_hist, // last four ops
  output logic [7:0] n_latch // edges seen
);
  initial op_hist = 8'h00;
  initial n_latch = 8'h00;
  task latch_edge;
    op_hist = {op_hist[5:0], op_addr};
    n_latch = n_latch + 8'h01;
    if (op_addr != OP_XFER)
      nibbles_reg[op_addr*4 +: 4] = nibble;
  endtask : latch_edge
  // either rising pin latches while the other is low
  always @(posedge wr_n)
    if (!sel_n)
      latch_edge();
  always @(posedge sel_n)
    if (!wr_n)
      latch_edge();
  // no else: the register holds when deselected
  always @*
  begin
    if (!zeroize_n)
      converter_code = 12'h000;
    else if (!sel_n && !wr_n && op_addr == OP_XFER)
      converter_code = nibbles_reg;
  end
endmodule : dac_device_model

// *** bench/dac_write_host_properties.sv ***
// Purpose: port checks for the dac host controller
// Assumes: one clock, async low reset
// Notes: pin timing floors come from the package, except select hold, written as a literal 5 cycles
`timescale 1ns/1ps
module dac_write_host_properties
  import dac_port_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic rst_n, // reset
  input wire logic [1:0] op_addr, // op
  input wire logic [3:0] nibble_out, // data
  input wire logic dev_sel_n, // select
  input wire logic dev_wr_n, // strobe
  input wire logic zeroize_n // clear
);
  localparam logic [7:0] SEL_CYC = ns_to_cycles(T_SEL_SETUP_NS);
  logic [7:0] sel_cnt, wr_cnt, clr_cnt;
  logic [1:0] prev_op;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // low-time counters; strobe and clear read at their closing edge, select at the strobe falling edge
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_cnt <= 8'h00;
      wr_cnt <= 8'h00;
      clr_cnt <= 8'h00;
      prev_op <= OP_XFER;
    end
    else
    begin
      sel_cnt <= dev_sel_n ? 8'h00 : sel_cnt + 8'h01;
      wr_cnt <= dev_wr_n ? 8'h00 : wr_cnt + 8'h01;
      clr_cnt <= zeroize_n ? 8'h00 : clr_cnt + 8'h01;
      prev_op <= $rose(dev_wr_n) ? op_addr : prev_op;
    end
  end
  a_strobe_in_select: assert property (!dev_wr_n |-> !dev_sel_n)
    else $error("strobe low while deselected");
  a_select_setup: assert property ($fell(dev_wr_n) |-> sel_cnt >= SEL_CYC)
    else $error("select setup short");
  a_strobe_width: assert property ($rose(dev_wr_n) |-> wr_cnt >= STROBE_CYC)
    else $error("strobe too short");
  a_select_hold: assert property ($rose(dev_wr_n) |-> !dev_sel_n [*5])
    else $error("select hold short");
  a_pins_steady: assert property (!$past(dev_wr_n) |-> $stable({op_addr, nibble_out}))
    else $error("pins moved under strobe");
  a_op_order: assert property ($rose(dev_wr_n) |-> op_addr == prev_op + 2'h1)
    else $error("operation out of order");
  a_clear_width: assert property ($rose(zeroize_n) |-> clr_cnt >= CLEAR_CYC)
    else $error("clear too short");
  c_transfer: cover property ($rose(dev_wr_n) && op_addr == OP_XFER);
  c_first_load: cover property ($rose(dev_wr_n) && op_addr == OP_LOW);
  c_clear: cover property ($rose(zeroize_n));
endmodule : dac_write_host_properties

bind dac_write_host dac_write_host_properties u_props (.core_clk(core_clk), .rst_n(rst_n),
  .op_addr(op_addr), .nibble_out(nibble_out), .dev_sel_n(dev_sel_n), .dev_wr_n(dev_wr_n),
  .zeroize_n(zeroize_n));

// *** bench/dac_write_host_tb.sv ***
// Purpose: self-checking bench for the dac host controller
// Assumes: device model on the pins, axi4-lite master tasks
// Notes: pin timing is left to the bound checker
`timescale 1ns/1ps
module dac_write_host_tb;
  import dac_port_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] s_awaddr = 4'h0;
  logic [3:0] s_araddr = 4'h0;
  logic [31:0] s_wdata = 32'h0;
  logic s_awvalid = 1'b0;
  logic s_wvalid = 1'b0;
  logic s_bready = 1'b0;
  logic s_arvalid = 1'b0;
  logic s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp, op_addr, r;
  logic [31:0] s_rdata, v;
  logic [3:0] nibble_out;
  logic dev_sel_n, dev_wr_n, zeroize_n;
  logic [11:0] nibbles_reg, converter_code;
  logic [7:0] op_hist, n_latch, n0;
  int fails = 0;
  int n_compared = 0;
  always #10 core_clk = ~core_clk;
  dac_write_host uut (.core_clk(core_clk), .rst_n(rst_n), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hf),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .op_addr(op_addr), .nibble_out(nibble_out), .dev_sel_n(dev_sel_n), .dev_wr_n(dev_wr_n),
    .zeroize_n(zeroize_n));
  dac_device_model dev (.op_addr(op_addr), .nibble(nibble_out), .sel_n(dev_sel_n),
    .wr_n(dev_wr_n), .zeroize_n(zeroize_n), .nibbles_reg(nibbles_reg),
    .converter_code(converter_code), .op_hist(op_hist), .n_latch(n_latch));
  task automatic results;
    if (fails == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge core_clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_awready)
        s_awvalid <= 1'b0;
      if (s_wready)
        s_wvalid <= 1'b0;
    end
    while (s_bvalid !== 1'b1);
    resp = s_bresp;
    s_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_arready)
        s_arvalid <= 1'b0;
    end
    while (s_rvalid !== 1'b1);
    d = s_rdata;
    check(s_rresp, RESP_OKAY);
    s_rready <= 1'b0;
  endtask : rd
  task automatic wait_idle;
    v = 32'h2;
    for (int i = 0; i < 300 && v[1] !== 1'b0; i++)
      rd(STATUS_OFFSET, v);
    check(v[1], 1'b0);
  endtask : wait_idle
  // dbl sends a second go while busy, which must not add a sequence
  task automatic load(input logic [11:0] c, input logic dbl);
    wr(CODE_OFFSET, {20'h0, c}, r);
    check(r, RESP_OKAY);
    n0 = n_latch;
    wr(CTRL_OFFSET, 32'h1, r);
    if (dbl)
      wr(CTRL_OFFSET, 32'h1, r);
    wait_idle();
    check(n_latch - n0, 8'h04);
    check(op_hist, 8'h1b);
    check(nibbles_reg, c);
    check(converter_code, c);
    rd(LAST_OFFSET, v);
    check(v, {20'h0, c});
  endtask : load
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    check({dev_sel_n, dev_wr_n, zeroize_n}, 3'h7);
    rd(STATUS_OFFSET, v);
    check(v, 32'h0);
    load(12'ha5c, 1'b0);
    load(12'hfff, 1'b1);
    load(12'h36c, 1'b0);
    rd(STATUS_OFFSET, v);
    check(v[0], 1'b1);
    wr(STATUS_OFFSET, 32'h1, r);
    rd(STATUS_OFFSET, v);
    check(v, 32'h0);
    wr(CTRL_OFFSET, 32'h2, r);
    wait_idle();
    repeat (CLEAR_CYC + 4) @(posedge core_clk);
    check(converter_code, 12'h000);
    check(nibbles_reg, 12'h36c);
    rd(LAST_OFFSET, v);
    check(v, 32'h0);
    wr(CTRL_OFFSET, 32'h4, r);
    rd(CTRL_OFFSET, v);
    check(v, 32'h4);
    wr(CODE_OFFSET, 32'h0c81, r);
    wait_idle();
    check(converter_code, 12'hc81);
    wr(LAST_OFFSET, 32'h1, r);
    check(r, RESP_SLVERR);
    results();
  end
  initial
  begin
    #400000;
    fails++;
    results();
  end
endmodule : dac_write_host_tb

// *** src/cycle_timer.sv ***
// Purpose: down counter that marks the end of a timed phase
// Assumes: load and count never in the same cycle as a second load
// Notes: done is high in the cycle the count reaches zero
`timescale 1ns/1ps
module cycle_timer
  import dac_port_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic rst_n, // async reset
  input wire logic load, // start a phase
  input wire logic [7:0] cycles, // phase length
  output logic done // phase over
);
  logic [7:0] count_reg;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_reg <= 8'h00;
    end
    else if (load)
    begin
      count_reg <= cycles - 8'h01;
    end
    else if (count_reg != 8'h00)
    begin
      count_reg <= count_reg - 8'h01;
    end
  end
  assign done = (count_reg == 8'h00) && !load;
endmodule : cycle_timer

// *** src/dac_port_pkg.sv ***
// Purpose: shared constants and types for the nibble dac write controller
// Assumes: 50 MHz core clock
// Notes: dac timing figures in ns, cycle counts derived and rounded up
package dac_port_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  // register map of the controller, one aligned word each
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] CODE_OFFSET = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h8;
  localparam logic [3:0] LAST_OFFSET = 4'hc;
  // ctrl field positions
  localparam int unsigned CTRL_GO_BIT = 0;
  localparam int unsigned CTRL_CLEAR_BIT = 1;
  localparam int unsigned CTRL_AUTO_BIT = 2;
  localparam logic [11:0] CODE_RESET = 12'h000;
  // axi answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // device operation addresses
  localparam logic [1:0] OP_LOW = 2'h0;
  localparam logic [1:0] OP_MID = 2'h1;
  localparam logic [1:0] OP_HIGH = 2'h2;
  localparam logic [1:0] OP_XFER = 2'h3;
  // device timing, worst case over temperature
  localparam int unsigned T_ADDR_SETUP_NS = 400;
  localparam int unsigned T_SEL_SETUP_NS = 350;
  localparam int unsigned T_STROBE_NS = 220;
  localparam int unsigned T_HOLD_NS = 100;
  localparam int unsigned T_CLEAR_NS = 300;
  function automatic logic [7:0] ns_to_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1)
    begin
      c = 1;
    end
    return c[7:0];
  endfunction : ns_to_cycles
  localparam logic [7:0] SETUP_CYC = ns_to_cycles(T_ADDR_SETUP_NS);
  localparam logic [7:0] STROBE_CYC = ns_to_cycles(T_STROBE_NS);
  localparam logic [7:0] HOLD_CYC = ns_to_cycles(T_HOLD_NS);
  localparam logic [7:0] CLEAR_CYC = ns_to_cycles(T_CLEAR_NS);
  typedef struct packed {
    logic [1:0] op_addr;
    logic [3:0] nibble;
    logic sel_n;
    logic wr_n;
  } dev_pins_type;
  typedef struct packed {
    logic go;
    logic clear;
    logic auto_go;
  } ctrl_type;
endpackage : dac_port_pkg

// *** src/dac_write_host.sv ***
// Purpose: host controller that loads a nibble-loaded 12-bit dac over its pins
// Assumes: axi4-lite slave for software, one clock, device pins static-ram style
// Notes: write code then go; busy shows in status
// Operation
// R01 - device owns four locations via operation address
// R02 - device decodes two address bits internally
// R03 - 00 low, 01 mid, 10 high nibble
// R04 - nibble latches on rising select or strobe
// R05 - latch with strobe, select as enable
// R06 - op 11 copies nibbles into converter
// R07 - low clear zeroes converter register asynchronously
// R08 - both strobes high means no operation
// R09 - every load is a static write cycle
// R10 - each operation is write to its location
// R11 - select from high address, op from low
// R12 - three nibble loads before transfer
// R13 - registers hold until rewritten or cleared
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module dac_write_host
  import dac_port_pkg::*;
(
  input wire logic core_clk, // 50 MHz clock
  input wire logic rst_n, // async reset, active low
  input wire logic [3:0] s_awaddr, // write address
  input wire logic s_awvalid, // write address valid
  output logic s_awready, // write address ready
  input wire logic [31:0] s_wdata, // write data
  input wire logic [3:0] s_wstrb, // write byte strobes
  input wire logic s_wvalid, // write data valid
  output logic s_wready, // write data ready
  output logic [1:0] s_bresp, // write response
  output logic s_bvalid, // write response valid
  input wire logic s_bready, // write response ready
  input wire logic [3:0] s_araddr, // read address
  input wire logic s_arvalid, // read address valid
  output logic s_arready, // read address ready
  output logic [31:0] s_rdata, // read data
  output logic [1:0] s_rresp, // read response
  output logic s_rvalid, // read data valid
  input wire logic s_rready, // read data ready
  output logic [1:0] op_addr, // operation address to device
  output logic [3:0] nibble_out, // data nibble to device
  output logic dev_sel_n, // device select, active low
  output logic dev_wr_n, // write strobe, active low
  output logic zeroize_n // converter clear, active low
);
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_SETUP = 7'b0000010,
    ST_STROBE = 7'b0000100,
    ST_HOLD = 7'b0001000,
    ST_NEXT = 7'b0010000,
    ST_CLEAR = 7'b0100000,
    ST_DONE = 7'b1000000
  } state_type;

  state_type state_reg;
  dev_pins_type pins_reg;
  ctrl_type ctrl_reg;
  logic [11:0] code_reg;
  logic [11:0] last_reg;
  logic [1:0] op_reg;
  logic zeroize_reg;
  logic busy_reg;
  logic done_flag_reg;
  logic have_aw_reg;
  logic have_w_reg;
  logic [3:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic timer_load;
  logic [7:0] timer_cycles;
  logic timer_done;
  logic wr_fire;
  logic go_pulse;
  logic clear_pulse;
  logic done_clear;

  function automatic logic [3:0] nibble_of(input logic [11:0] code, input logic [1:0] op);
    logic [3:0] n;
    n = 4'h0;
    case (op)
      OP_LOW: n = code[3:0];
      OP_MID: n = code[7:4];
      OP_HIGH: n = code[11:8];
      default: n = 4'h0;
    endcase
    return n;
  endfunction : nibble_of

  cycle_timer u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(timer_load),
    .cycles(timer_cycles),
    .done(timer_done)
  );

  // write channel capture: address and data taken in either order
  assign wr_fire = have_aw_reg && have_w_reg && !s_bvalid;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      have_aw_reg <= 1'b0;
      have_w_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
    end
    else
    begin
      s_awready <= !have_aw_reg && !s_awready && s_awvalid;
      s_wready <= !have_w_reg && !s_wready && s_wvalid;
      if (s_awvalid && s_awready)
      begin
        have_aw_reg <= 1'b1;
        aw_addr_reg <= s_awaddr;
      end
      if (s_wvalid && s_wready)
      begin
        have_w_reg <= 1'b1;
        w_data_reg <= s_wdata;
        w_strb_reg <= s_wstrb;
      end
      if (wr_fire)
      begin
        have_aw_reg <= 1'b0;
        have_w_reg <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= (aw_addr_reg == CTRL_OFFSET || aw_addr_reg == CODE_OFFSET ||
                    aw_addr_reg == STATUS_OFFSET) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_bvalid && s_bready)
      begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // go or clear while busy is dropped; software polls busy first
  assign go_pulse = wr_fire && aw_addr_reg == CTRL_OFFSET && w_strb_reg[0] &&
                    w_data_reg[CTRL_GO_BIT];
  assign clear_pulse = wr_fire && aw_addr_reg == CTRL_OFFSET && w_strb_reg[0] &&
                       w_data_reg[CTRL_CLEAR_BIT];
  assign done_clear = wr_fire && aw_addr_reg == STATUS_OFFSET && w_strb_reg[0] &&
                      w_data_reg[0];

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      code_reg <= CODE_RESET;
      ctrl_reg <= '0;
    end
    else if (wr_fire)
    begin
      if (aw_addr_reg == CODE_OFFSET)
      begin
        if (w_strb_reg[0])
        begin
          code_reg[7:0] <= w_data_reg[7:0];
        end
        if (w_strb_reg[1])
        begin
          code_reg[11:8] <= w_data_reg[11:8];
        end
      end
      if (aw_addr_reg == CTRL_OFFSET && w_strb_reg[0])
      begin
        ctrl_reg.auto_go <= w_data_reg[CTRL_AUTO_BIT];
      end
    end
  end

  // sequencer: each nibble and the transfer is one static write cycle [R09] [R10]
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      op_reg <= OP_LOW;
      busy_reg <= 1'b0;
      last_reg <= CODE_RESET;
      timer_load <= 1'b0;
      timer_cycles <= 8'h01;
    end
    else
    begin
      timer_load <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (clear_pulse)
          begin
            busy_reg <= 1'b1;
            timer_load <= 1'b1;
            timer_cycles <= CLEAR_CYC;
            state_reg <= ST_CLEAR;
          end
          else if (go_pulse || (ctrl_reg.auto_go && wr_fire && aw_addr_reg == CODE_OFFSET))
          begin
            busy_reg <= 1'b1;
            op_reg <= OP_LOW; // three nibbles first, then transfer [R12]
            timer_load <= 1'b1;
            timer_cycles <= SETUP_CYC;
            state_reg <= ST_SETUP;
          end
        end
        ST_SETUP:
        begin
          if (timer_done && !timer_load)
          begin
            timer_load <= 1'b1;
            timer_cycles <= STROBE_CYC;
            state_reg <= ST_STROBE;
          end
        end
        ST_STROBE:
        begin
          if (timer_done && !timer_load)
          begin
            timer_load <= 1'b1;
            timer_cycles <= HOLD_CYC;
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          if (timer_done && !timer_load)
          begin
            state_reg <= ST_NEXT;
          end
        end
        ST_NEXT:
        begin
          if (op_reg == OP_XFER)
          begin
            last_reg <= code_reg;
            state_reg <= ST_DONE;
          end
          else
          begin
            op_reg <= op_reg + 2'h1; // low, mid, high, transfer [R03] [R06]
            timer_load <= 1'b1;
            timer_cycles <= SETUP_CYC;
            state_reg <= ST_SETUP;
          end
        end
        ST_CLEAR:
        begin
          if (timer_done && !timer_load)
          begin
            last_reg <= CODE_RESET; // nibble copies untouched by clear [R07] [R13]
            state_reg <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          busy_reg <= 1'b0;
          state_reg <= ST_IDLE;
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // done flag: set wins over a software clear
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done_flag_reg <= 1'b0;
    end
    else if (state_reg == ST_DONE)
    begin
      done_flag_reg <= 1'b1;
    end
    else if (done_clear)
    begin
      done_flag_reg <= 1'b0;
    end
  end

  // pin drive: select is the enable held across the cycle, strobe rising edge latches [R05] [R04]
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pins_reg <= '{op_addr: OP_LOW, nibble: 4'h0, sel_n: 1'b1, wr_n: 1'b1};
      zeroize_reg <= 1'b1;
    end
    else
    begin
      zeroize_reg <= (state_reg != ST_CLEAR); // pulse is CLEAR_CYC + 1 cycles long [R07]
      pins_reg.op_addr <= op_reg; // device decodes these two bits [R01] [R02] [R11]
      pins_reg.nibble <= nibble_of(code_reg, op_reg);
      // idle with both high: device does nothing [R08]
      pins_reg.sel_n <= !(state_reg == ST_SETUP || state_reg == ST_STROBE ||
                          state_reg == ST_HOLD);
      pins_reg.wr_n <= (state_reg != ST_STROBE);
    end
  end

  assign op_addr = pins_reg.op_addr;
  assign nibble_out = pins_reg.nibble;
  assign dev_sel_n = pins_reg.sel_n;
  assign dev_wr_n = pins_reg.wr_n;
  assign zeroize_n = zeroize_reg;

  // read channel
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= RESP_OKAY;
    end
    else
    begin
      s_arready <= !s_rvalid && !s_arready && s_arvalid;
      if (s_arvalid && s_arready)
      begin
        s_rvalid <= 1'b1;
        s_rresp <= RESP_OKAY;
        case (s_araddr)
          CTRL_OFFSET: s_rdata <= {29'h0, ctrl_reg.auto_go, 2'h0};
          CODE_OFFSET: s_rdata <= {20'h0, code_reg};
          STATUS_OFFSET: s_rdata <= {30'h0, busy_reg, done_flag_reg};
          LAST_OFFSET: s_rdata <= {20'h0, last_reg};
          default:
          begin
            s_rdata <= 32'h0000_0000;
            s_rresp <= RESP_SLVERR;
          end
        endcase
      end
      else if (s_rvalid && s_rready)
      begin
        s_rvalid <= 1'b0;
      end
    end
  end
endmodule : dac_write_host
